// ### xps_pkg.sv
package xps_pkg;
    // ****************************************
    // geometry
    // ****************************************
    localparam int N_OUT      = 8;
    localparam int N_IN       = 16;
    localparam int SEL_W      = 4;
    localparam int ADDR_W     = 3;
    localparam int SLOT_W     = 5;
    localparam int SHIFT_LEN  = 80;
    localparam int USED_W     = N_OUT * SLOT_W;
    localparam int ROUTE_W    = N_OUT * N_IN;
    // ****************************************
    // slot field positions (first shifted bit lands highest)
    // ****************************************
    localparam int FLD_EN     = 0;
    localparam int FLD_IN0    = 4;
    // ****************************************
    // reset values and load-mode codes
    // ****************************************
    localparam logic [SHIFT_LEN-1:0] SHIFT_RST = '0;
    localparam logic [USED_W-1:0]    RANK2_RST = '0;
    localparam logic                 MODE_SER  = 1'b0;
    localparam logic                 MODE_PAR  = 1'b1;
endpackage : xps_pkg

// ### xps_dec_if.sv
`timescale 1ns/1ps
interface xps_dec_if;
    import xps_pkg::*;
    logic [USED_W-1:0]  slots;
    logic [ROUTE_W-1:0] onehot;
    logic [N_OUT-1:0]   en;
    modport dec (input slots, output onehot, output en);
    modport ctl (output slots, input onehot, input en);
endinterface : xps_dec_if

// ### xps_decode.sv
`timescale 1ns/1ps
module xps_decode
    import xps_pkg::*;
(
    xps_dec_if.dec dif
);
    // ****************************************
    // per-output one-of-sixteen decode
    // ****************************************
    genvar k;
    generate
        for (k = 0; k < N_OUT; k++) begin : g_out
            logic [SLOT_W-1:0] fld;
            logic [SEL_W-1:0]  sel;
            assign fld = dif.slots[k*SLOT_W +: SLOT_W];
            assign sel = {fld[FLD_IN0-3], fld[FLD_IN0-2], fld[FLD_IN0-1], fld[FLD_IN0]};
            assign dif.en[k] = fld[FLD_EN];
            // one path or none per output
            assign dif.onehot[k*N_IN +: N_IN] = fld[FLD_EN] ? (N_IN'(1) << sel) : '0;
        end
    endgenerate
endmodule : xps_decode

// ### xps_ctrl.sv
`timescale 1ns/1ps
// Operation
// - eight outputs, each routable from any of sixteen inputs
// - each output enables exactly one input path or none
// - three output-select lines give output number, line 0 is LSB
// - four input-select lines give input number, LSB first
// - enable bit low disables output, no input routed
// - loading writes only first rank; routing waits for transfer
// - one global second rank updates all outputs together
// - shifted-out bits appear on serial output for daisy chain
// - active-low output-disable pin forces all outputs off
// - serial: falling clock shifts one bit; bit exits after 80 clocks
// - parallel: falling clock writes five data lines into addressed slot
// - transfer strobe low makes second rank follow shift register
// - chip select high ignores clock, data, strobe; state unchanged
module xps_ctrl
    import xps_pkg::*;
(
    input  wire logic                I_CLK,
    input  wire logic                I_RESET,
    input  wire logic                I_CHIP_SEL_N,
    input  wire logic                I_XFER_N,
    input  wire logic                I_SCLK,
    input  wire logic                I_SER_DATA,
    input  wire logic                I_LOAD_MODE_SEL,
    input  wire logic [ADDR_W-1:0]   I_OUT_SEL,
    input  wire logic [SEL_W-1:0]    I_IN_SEL,
    input  wire logic                I_OUTPUT_ENABLE_BIT,
    input  wire logic                I_OUT_DIS_N,
    output logic                     O_SER_DATA,
    output logic [ROUTE_W-1:0]       O_ROUTE,
    output logic [N_OUT-1:0]         O_OUT_EN
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [SHIFT_LEN-1:0] shift;
        logic [USED_W-1:0]    rank2;
        logic                 sclk_prev;
        logic                 sdo;
        logic [ROUTE_W-1:0]   route;
        logic [N_OUT-1:0]     en;
    } xps_state_t;

    xps_state_t st_reg;
    xps_state_t st_next;
    xps_dec_if  dif ();
    logic       fall;
    logic       sel_ok;
    logic [SLOT_W-1:0] pslot;

    xps_decode u_dec (
        .dif (dif)
    );

    assign dif.slots = st_reg.rank2;
    assign fall      = st_reg.sclk_prev & ~I_SCLK;
    assign sel_ok    = ~I_CHIP_SEL_N;
    assign pslot     = {I_IN_SEL[0], I_IN_SEL[1], I_IN_SEL[2], I_IN_SEL[3], I_OUTPUT_ENABLE_BIT};

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        st_next.sclk_prev = I_SCLK;
        if (sel_ok && I_XFER_N && fall) begin
            if (I_LOAD_MODE_SEL == MODE_SER) begin
                st_next.shift = {st_reg.shift[SHIFT_LEN-2:0], I_SER_DATA};
            end else begin
                for (int k = 0; k < N_OUT; k++) begin
                    if (I_OUT_SEL == ADDR_W'(k)) begin
                        st_next.shift[k*SLOT_W +: SLOT_W] = pslot;
                    end
                end
            end
        end
        if (sel_ok && !I_XFER_N) begin
            st_next.rank2 = st_next.shift[USED_W-1:0];
        end
        st_next.sdo   = st_next.shift[SHIFT_LEN-1];
        st_next.route = I_OUT_DIS_N ? dif.onehot : '0;
        st_next.en    = I_OUT_DIS_N ? dif.en : '0;
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            st_reg <= '{shift: SHIFT_RST, rank2: RANK2_RST, sclk_prev: 1'b0, sdo: 1'b0, route: '0, en: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign O_SER_DATA = st_reg.sdo;
    assign O_ROUTE    = st_reg.route;
    assign O_OUT_EN   = st_reg.en;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    sequence s_ser_shift;
        sel_ok && I_XFER_N && fall && (I_LOAD_MODE_SEL == MODE_SER);
    endsequence
    sequence s_par_write;
        sel_ok && I_XFER_N && fall && (I_LOAD_MODE_SEL == MODE_PAR);
    endsequence

    ser_shift_in_a: assert property (s_ser_shift |=> st_reg.shift[0] == $past(I_SER_DATA)
        && st_reg.shift[SHIFT_LEN-1:1] == $past(st_reg.shift[SHIFT_LEN-2:0]))
        else $error("serial shift wrong");
    ser_out_tap_a: assert property (O_SER_DATA == st_reg.shift[SHIFT_LEN-1])
        else $error("serial output not last stage");
    par_slot_wr_a: assert property (s_par_write |=>
        st_reg.shift[$past(I_OUT_SEL)*SLOT_W +: SLOT_W] == $past(pslot))
        else $error("parallel slot not written");
    cs_hold_st_a: assert property (!sel_ok |=> $stable(st_reg.shift) && $stable(st_reg.rank2))
        else $error("state changed while deselected");
    rank2_hold_a: assert property (I_XFER_N |=> $stable(st_reg.rank2))
        else $error("second rank changed while strobe high");
    rank2_follow_a: assert property (sel_ok && !I_XFER_N |=> st_reg.rank2 == st_reg.shift[USED_W-1:0])
        else $error("second rank not transparent");
    route_onehot_a: assert property ($onehot0(O_ROUTE[N_IN-1:0]) && $onehot0(O_ROUTE[ROUTE_W-1 -: N_IN]))
        else $error("output has two paths");
    dis_all_off_a: assert property (!I_OUT_DIS_N |=> O_OUT_EN == '0 && O_ROUTE == '0)
        else $error("outputs not disabled");
    route_track_a: assert property (I_OUT_DIS_N && $stable(st_reg.rank2) |=>
        O_OUT_EN == $past(dif.en) && O_ROUTE == $past(dif.onehot))
        else $error("routing does not track second rank");

    // ****************************************
    // per-output checks
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < N_OUT; g++) begin : g_chk
            out_onehot_a: assert property ($onehot0(O_ROUTE[g*N_IN +: N_IN]))
                else $error("output has two paths");
            off_no_path_a: assert property (!O_OUT_EN[g] |-> O_ROUTE[g*N_IN +: N_IN] == '0)
                else $error("disabled output still routed");
        end
    endgenerate
endmodule : xps_ctrl

// ### xps_host.sv
`timescale 1ns/1ps
module xps_host
    import xps_pkg::*;
(
    input  wire logic         i_clk,
    output logic              o_cs_n,
    output logic              o_xfer_n,
    output logic              o_sclk,
    output logic              o_sd,
    output logic              o_mode,
    output logic [ADDR_W-1:0] o_osel,
    output logic [SLOT_W-1:0] o_slot
);
    initial begin
        {o_cs_n, o_xfer_n, o_sclk, o_sd, o_mode, o_osel, o_slot} = {2'b01, 11'h000};
    end
    // one clock fall, data held until taken, then lines scrambled
    task automatic put(input logic m, input logic d, input logic [ADDR_W-1:0] a, input logic [SLOT_W-1:0] p);
        #1 {o_sclk, o_mode, o_sd, o_osel, o_slot} = {1'b1, m, d, a, p};
        @(posedge i_clk);
        #1 o_sclk = 1'b0;
        @(posedge i_clk);
        #1 {o_sd, o_slot} = ~{o_sd, o_slot};
    endtask : put
    // chip select level, changed off the sampling edge
    task automatic sel(input logic v);
        #1 o_cs_n = v;
    endtask : sel
    // strobe low for one sample
    task automatic xfer();
        #1 o_xfer_n = 1'b0;
        @(posedge i_clk);
        #1 o_xfer_n = 1'b1;
        @(posedge i_clk);
        #1;
    endtask : xfer
endmodule : xps_host

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top
    import xps_pkg::*;
;
    logic                 clk, rst, dis_n, cs_n, xfer_n, sclk, sd, mode, o_sd;
    logic [ADDR_W-1:0]    osel;
    logic [SLOT_W-1:0]    slot;
    logic [ROUTE_W-1:0]   route;
    logic [N_OUT-1:0]     oen;
    logic [SHIFT_LEN-1:0] sh, r2;
    int                   mismatches, n_tests;
    always #4 clk = ~clk;
    xps_host xps_host_i (.i_clk(clk), .o_cs_n(cs_n), .o_xfer_n(xfer_n), .o_sclk(sclk), .o_sd(sd),
        .o_mode(mode), .o_osel(osel), .o_slot(slot));
    xps_ctrl xps_ctrl_i (.I_CLK(clk), .I_RESET(rst), .I_CHIP_SEL_N(cs_n), .I_XFER_N(xfer_n), .I_SCLK(sclk),
        .I_SER_DATA(sd), .I_LOAD_MODE_SEL(mode), .I_OUT_SEL(osel), .I_IN_SEL(slot[3:0]),
        .I_OUTPUT_ENABLE_BIT(slot[4]), .I_OUT_DIS_N(dis_n), .O_SER_DATA(o_sd), .O_ROUTE(route), .O_OUT_EN(oen));
    task automatic chk(input string s);
        logic [ROUTE_W-1:0] er;
        logic [N_OUT-1:0]   ee;
        er = '0;
        ee = '0;
        for (int k = 0; k < N_OUT; k++) begin
            if (dis_n && r2[5*k]) begin
                ee[k] = 1'b1;
                er[N_IN*k + {r2[5*k+1], r2[5*k+2], r2[5*k+3], r2[5*k+4]}] = 1'b1;
            end
        end
        n_tests++;
        if (route !== er || oen !== ee || o_sd !== sh[SHIFT_LEN-1]) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, s);
        end
    endtask : chk
    task automatic stop_test();
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        #100000;
        mismatches++;
        stop_test();
    end
    initial begin
        logic              d;
        logic [SLOT_W-1:0] p;
        {clk, rst, dis_n} = 3'b111;
        sh = '0;
        r2 = '0;
        void'($urandom(32'h0000_066e));
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        chk("reset");
        for (int i = 0; i < SHIFT_LEN; i++) begin
            d = 1'($urandom);
            xps_host_i.put(MODE_SER, d, '0, '0);
            sh = {sh[SHIFT_LEN-2:0], d};
            chk("shift");
        end
        xps_host_i.xfer();
        r2 = sh;
        chk("serial update");
        for (int k = 0; k < N_OUT; k++) begin
            p = 5'($urandom);
            xps_host_i.put(MODE_PAR, 1'b0, 3'(k), p);
            sh[5*k +: 5] = {p[0], p[1], p[2], p[3], p[4]};
            chk("slot");
        end
        xps_host_i.xfer();
        r2 = sh;
        chk("parallel update");
        xps_host_i.sel(1'b1);
        xps_host_i.put(MODE_SER, 1'b1, '0, '0);
        xps_host_i.put(MODE_PAR, 1'b0, 3'h7, 5'h1f);
        xps_host_i.xfer();
        chk("deselected");
        xps_host_i.sel(1'b0);
        dis_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("disabled");
        dis_n = 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("enabled");
        stop_test();
    end
endmodule : tb_top
